// >>> src/ptcp_cfg.svh
// Constants of the PCI target, config space and EEPROM preload
`ifndef PTCP_CFG_SVH
`define PTCP_CFG_SVH
`define PTCP_OFS_ID      8'h00
`define PTCP_OFS_CMDSTS  8'h04
`define PTCP_OFS_CLASS   8'h08
`define PTCP_OFS_LAT     8'h0c
`define PTCP_OFS_BAR     8'h10
`define PTCP_OFS_SUBSYS  8'h2c
`define PTCP_OFS_INTR    8'h3c
`define PTCP_CMD_MEM     1
`define PTCP_CMD_BME     2
`define PTCP_CMD_PER     6
`define PTCP_CMD_FBB     9
`define PTCP_STS_MDPE    24
`define PTCP_STS_RTA     28
`define PTCP_STS_RMA     29
`define PTCP_STS_DPE     31
`define PTCP_STS_FIXED   16'h0280
`define PTCP_CLASS_REV   32'h04800001
`define PTCP_INTPIN      8'h01
`define PTCP_SUBSYS_DEF  16'h0000
`define PTCP_MAXLAT_DEF  8'h26
`define PTCP_MINGNT_DEF  8'h0f
`define PTCP_BAR_LSB     9
`define PTCP_EE_ADDR     7'h50
`define PTCP_EE_BYTES    6
`define PTCP_CLK_NS      4
`define PTCP_I2C_QTR_NS  2500
`define PTCP_MABORT_CLKS 5
`define PTCP_BC_MRD      4'h6
`define PTCP_BC_MWR      4'h7
`define PTCP_BC_CRD      4'ha
`define PTCP_BC_CWR      4'hb
`define PTCP_BC_MRM      4'hc
`define PTCP_BC_MRL      4'he
`define PTCP_BC_MWI      4'hf
`endif

// >>> src/ptcp_pkg.sv
// Types shared by the PCI interface and the EEPROM loader
`default_nettype none
package ptcp_pkg;
	typedef enum logic [2:0] {
		T_IDLE = 3'b000, T_DECODE = 3'b001, T_RWAIT = 3'b010,
		T_DATA = 3'b011, T_DRAIN = 3'b100, T_TURN = 3'b101
	} ptcp_tstate_t;
	typedef enum logic [2:0] {
		M_IDLE = 3'b000, M_REQ = 3'b001, M_ADDR = 3'b010,
		M_DATA = 3'b011, M_TURN = 3'b100
	} ptcp_mstate_t;
	typedef enum logic [1:0] {
		I_START = 2'b00, I_BIT = 2'b01, I_STOP = 2'b10, I_DONE = 2'b11
	} ptcp_istate_t;
	typedef struct packed {
		logic [31:0] ad;
		logic [3:0]  cbe_n;
		logic        par;
		logic        frame_n;
		logic        irdy_n;
		logic        trdy_n;
		logic        devsel_n;
		logic        stop_n;
		logic        idsel;
		logic        gnt_n;
	} ptcp_pci_in_t;
	typedef struct packed {
		logic [31:0] ad;
		logic        ad_oe;
		logic [3:0]  cbe_n;
		logic        cbe_oe;
		logic        par;
		logic        par_oe;
		logic        frame_n;
		logic        irdy_n;
		logic        mctl_oe;
		logic        trdy_n;
		logic        devsel_n;
		logic        stop_n;
		logic        tctl_oe;
		logic        perr_n;
		logic        perr_oe;
		logic        req_n;
	} ptcp_pci_out_t;
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [8:0]  offs;
		logic [31:0] wdata;
		logic [3:0]  be_n;
	} ptcp_reg_req_t;
	typedef struct packed {
		logic        valid;
		logic        write;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic [3:0]  be_n;
	} ptcp_dma_req_t;
	typedef struct packed {
		logic        done;
		logic        ok;
		logic [47:0] bytes;
	} ptcp_preload_t;
endpackage
`default_nettype wire

// >>> src/ptcp_eeprom_loader.sv
// I2C master that reads the preload bytes from the serial EEPROM
`include "ptcp_cfg.svh"
`default_nettype none
module ptcp_eeprom_loader #(
	parameter int QTR_CLKS = (`PTCP_I2C_QTR_NS + `PTCP_CLK_NS - 1) / `PTCP_CLK_NS
) (
	// Clock and reset
	input  wire logic              clk,
	input  wire logic              srst,
	// Open-drain I2C pins
	input  wire logic              scl_in,
	output logic                   scl_out,
	output logic                   scl_oe,
	input  wire logic              sda_in,
	output logic                   sda_out,
	output logic                   sda_oe,
	// Preload result
	output ptcp_pkg::ptcp_preload_t result
);
	localparam logic [3:0] LAST = 4'(3 + `PTCP_EE_BYTES - 1);
	typedef struct packed {
		ptcp_pkg::ptcp_istate_t st;
		logic [1:0]             q;
		logic [15:0]            div;
		logic [3:0]             bitn;
		logic [7:0]             sh;
		logic [3:0]             idx;
		logic [47:0]            buffer;
		logic                   fail;
		logic                   scl_oe;
		logic                   sda_oe;
	} ptcp_ee_t;
	ptcp_ee_t state;
	ptcp_ee_t next_state;

	// Byte sent at each step: address write, word pointer, address read
	function automatic logic [7:0] tx_byte(input logic [3:0] idx);
		case (idx)
			4'h0: tx_byte = {`PTCP_EE_ADDR, 1'b0};
			4'h2: tx_byte = {`PTCP_EE_ADDR, 1'b1};
			default: tx_byte = 8'h00;
		endcase
	endfunction

	// Quarter-bit sequencer; SCL held low by a slave stretches the low phase
	always_comb
	begin
		logic tick;
		logic rx;
		next_state = state;
		tick = (state.div == 16'(QTR_CLKS - 1));
		rx = (state.idx >= 4'h3);
		next_state.div = tick ? 16'h0000 : state.div + 16'h0001;
		if (tick && state.st != ptcp_pkg::I_DONE && !(state.q == 2'h2 && !scl_in))
		begin
			next_state.q = state.q + 2'h1;
			case (state.st)
				ptcp_pkg::I_START:
				case (state.q)
					2'h0: begin next_state.sda_oe = 1'b0; next_state.scl_oe = 1'b1; end
					2'h1: next_state.scl_oe = 1'b0;
					2'h2: next_state.sda_oe = 1'b1;
					default:
					begin
						next_state.scl_oe = 1'b1;
						next_state.st = ptcp_pkg::I_BIT;
						next_state.bitn = 4'h0;
						next_state.sh = tx_byte(state.idx);
					end
				endcase
				ptcp_pkg::I_BIT:
				case (state.q)
					2'h0:
					if (state.bitn == 4'h8)
						next_state.sda_oe = rx && state.idx != LAST;
					else
						next_state.sda_oe = !rx && !state.sh[7];
					2'h1: next_state.scl_oe = 1'b0;
					2'h2:
					if (state.bitn == 4'h8 && !rx && sda_in)
						next_state.fail = 1'b1;
					else if (state.bitn != 4'h8 && rx)
						next_state.sh = {state.sh[6:0], sda_in};
					default:
					begin
						next_state.scl_oe = 1'b1;
						next_state.bitn = state.bitn + 4'h1;
						if (!rx)
							next_state.sh = {state.sh[6:0], 1'b0};
						if (state.bitn == 4'h8)
						begin
							next_state.bitn = 4'h0;
							next_state.idx = state.idx + 4'h1;
							next_state.sh = tx_byte(state.idx + 4'h1);
							if (rx)
								next_state.buffer = {state.buffer[39:0], state.sh};
							if (state.fail || state.idx == LAST)
								next_state.st = ptcp_pkg::I_STOP;
							else if (state.idx == 4'h1)
								next_state.st = ptcp_pkg::I_START;
						end
					end
				endcase
				ptcp_pkg::I_STOP:
				case (state.q)
					2'h0: next_state.sda_oe = 1'b1;
					2'h1: next_state.scl_oe = 1'b0;
					2'h2: next_state.sda_oe = 1'b0;
					default: next_state.st = ptcp_pkg::I_DONE;
				endcase
				default: next_state.st = ptcp_pkg::I_DONE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (srst)
			state <= '{st: ptcp_pkg::I_START, default: '0};
		else
			state <= next_state;
	end

	assign scl_out = 1'b0;
	assign sda_out = 1'b0;
	assign scl_oe = state.scl_oe;
	assign sda_oe = state.sda_oe;
	assign result.done = (state.st == ptcp_pkg::I_DONE);
	assign result.ok = (state.st == ptcp_pkg::I_DONE) && !state.fail;
	assign result.bytes = state.buffer;
endmodule
`default_nettype wire

// >>> src/ptcp_pci_if.sv
// PCI target with config space, EEPROM preload and a DMA initiator
// Overview of operation
// - Target and initiator follow PCI 2.1
// - Honour byte enables, 32-bit data
// - Accept fast back-to-back transactions; the target misses one that follows a data phase it served itself
// - Check data parity, report on PERR#
// - Address parity error: never claim
// - Decode only config and register window
// - Payload moves only by own bus mastering
// - Arbiter picks channel for the initiator
// - Unimplemented config reads zero, ignores writes
// - Preload from EEPROM at address 1010000
// - Preload takes about 1 ms
// - Retry every access during the preload
// - Three video channels, 384 dwords FIFO
// - Four audio channels, 24 dwords each
// - Expansion port: direct access and DMA
// - Per-channel page-table address translation
// - Subsystem IDs read-only, preloaded, default 0000H
// - Max_Lat read-only, preloaded, default 26H
// - Min_Gnt read-only, preloaded, default 0FH
// - Base address low bits read zero
`include "ptcp_cfg.svh"
`default_nettype none
module ptcp_pci_if #(
	parameter int NUM_CH   = 8, // 3 video, 4 audio, 1 expansion
	parameter int QTR_CLKS = (`PTCP_I2C_QTR_NS + `PTCP_CLK_NS - 1) / `PTCP_CLK_NS,
	parameter logic [15:0] DEVICE_ID = 16'h0001, // Arbitrary value
	parameter logic [15:0] VENDOR_ID = 16'hfffe  // Arbitrary value
) (
	// Clock and reset
	input  wire logic                    clk,
	input  wire logic                    srst,
	// PCI bus pins
	input  wire ptcp_pkg::ptcp_pci_in_t  pci_in,
	output ptcp_pkg::ptcp_pci_out_t      pci_out,
	// EEPROM I2C pins
	input  wire logic                    scl_in,
	output logic                         scl_out,
	output logic                         scl_oe,
	input  wire logic                    sda_in,
	output logic                         sda_out,
	output logic                         sda_oe,
	// Programmable register window
	output ptcp_pkg::ptcp_reg_req_t      reg_req,
	input  wire logic [31:0]             reg_rdata,
	// Local DMA channels
	input  wire ptcp_pkg::ptcp_dma_req_t dma_req [NUM_CH],
	output logic [NUM_CH-1:0]            dma_done,
	output logic                         dma_err,
	output logic [31:0]                  dma_rdata,
	// Status
	output logic                         preload_busy
);
	localparam int CW = $clog2(NUM_CH);
	typedef struct packed {
		ptcp_pkg::ptcp_tstate_t  tst;
		ptcp_pkg::ptcp_mstate_t  mst;
		ptcp_pkg::ptcp_pci_out_t pci;
		ptcp_pkg::ptcp_reg_req_t rq;
		logic                    prev_frame_n;
		logic [31:0]             addr;
		logic [3:0]              bcmd;
		logic                    apar;
		logic                    dpar_pend;
		logic                    dpar_mst;
		logic                    dpar;
		logic [1:0]              perr_cnt;
		logic [3:0]              cmd;
		logic                    dpe;
		logic                    rma;
		logic                    rta;
		logic                    mdpe;
		logic [7:0]              lat;
		logic [22:0]             bar;
		logic [7:0]              intline;
		logic [15:0]             ssvid;
		logic [15:0]             ssid;
		logic [7:0]              maxlat;
		logic [7:0]              mingnt;
		logic                    loaded;
		logic [CW-1:0]           gidx;
		logic [CW-1:0]           last;
		logic [2:0]              wcnt;
		logic [NUM_CH-1:0]       done;
		logic                    err;
		logic [31:0]             rdata;
	} ptcp_if_t;
	ptcp_if_t               state;
	ptcp_if_t               next_state;
	ptcp_pkg::ptcp_preload_t pl;
	logic [NUM_CH-1:0]      req_vec;

	// Serial EEPROM reader, started by reset
	ptcp_eeprom_loader #(
		.QTR_CLKS (QTR_CLKS)
	) u_loader (
		.clk     (clk),
		.srst    (srst),
		.scl_in  (scl_in),
		.scl_out (scl_out),
		.scl_oe  (scl_oe),
		.sda_in  (sda_in),
		.sda_out (sda_out),
		.sda_oe  (sda_oe),
		.result  (pl)
	);

	// Even parity over AD and C/BE#
	function automatic logic par36(input logic [31:0] ad, input logic [3:0] cbe);
		par36 = ^{ad, cbe};
	endfunction

	// Byte lanes enabled by active-low byte enables
	function automatic logic [31:0] lanes(input logic [3:0] be_n);
		lanes = {{8{!be_n[3]}}, {8{!be_n[2]}}, {8{!be_n[1]}}, {8{!be_n[0]}}};
	endfunction

	// Round-robin choice starting after the last served channel
	function automatic logic [CW-1:0] pick(input logic [NUM_CH-1:0] v, input logic [CW-1:0] last);
		logic [CW-1:0] idx;
		pick = last;
		for (int i = NUM_CH; i >= 1; i--)
		begin
			idx = CW'((int'(last) + i) % NUM_CH);
			if (v[idx])
				pick = idx;
		end
	endfunction

	// Config dword; anything not listed reads zero
	function automatic logic [31:0] cfg_read(input ptcp_if_t s, input logic [7:0] ofs);
		case (ofs)
			`PTCP_OFS_ID:     cfg_read = {DEVICE_ID, VENDOR_ID};
			`PTCP_OFS_CMDSTS: cfg_read = {`PTCP_STS_FIXED | {s.dpe, 1'b0, s.rma, s.rta, 3'h0,
				s.mdpe, 8'h00}, 6'h00, s.cmd[3], 2'h0, s.cmd[2], 3'h0, s.cmd[1:0], 1'b0};
			`PTCP_OFS_CLASS:  cfg_read = `PTCP_CLASS_REV;
			`PTCP_OFS_LAT:    cfg_read = {16'h0000, s.lat, 8'h00};
			`PTCP_OFS_BAR:    cfg_read = {s.bar, 9'h000};
			`PTCP_OFS_SUBSYS: cfg_read = {s.ssid, s.ssvid};
			`PTCP_OFS_INTR:   cfg_read = {s.maxlat, s.mingnt, `PTCP_INTPIN, s.intline};
			default:          cfg_read = 32'h00000000;
		endcase
	endfunction

	always_comb
	begin
		for (int i = 0; i < NUM_CH; i++)
			req_vec[i] = dma_req[i].valid;
	end

	// Target, initiator, parity and preload capture in one next-state pass
	always_comb
	begin
		logic        is_cfg;
		logic        is_mem;
		logic        is_wr;
		logic        busy;
		logic [31:0] m;
		logic [31:0] w;
		logic [31:0] clr;
		next_state = state;
		next_state.prev_frame_n = pci_in.frame_n;
		next_state.rq.valid = 1'b0;
		next_state.done = '0;
		next_state.err = 1'b0;
		next_state.dpar_pend = 1'b0;
		busy = !pl.done;
		is_wr = (state.bcmd == `PTCP_BC_MWR) || (state.bcmd == `PTCP_BC_MWI)
			|| (state.bcmd == `PTCP_BC_CWR);
		is_cfg = pci_in.idsel && state.addr[1:0] == 2'b00
			&& (state.bcmd == `PTCP_BC_CRD || state.bcmd == `PTCP_BC_CWR);
		is_mem = state.cmd[0] && state.addr[31:`PTCP_BAR_LSB] == state.bar
			&& (state.bcmd == `PTCP_BC_MRD || state.bcmd == `PTCP_BC_MWR
			|| state.bcmd == `PTCP_BC_MRM || state.bcmd == `PTCP_BC_MRL
			|| state.bcmd == `PTCP_BC_MWI);
		m = lanes(pci_in.cbe_n);
		w = (cfg_read(state, state.addr[7:0]) & ~m) | (pci_in.ad & m);
		clr = '0;

		// Preloaded fields are taken once; a failed read keeps defaults
		if (pl.done && !state.loaded)
		begin
			next_state.loaded = 1'b1;
			if (pl.ok)
			begin
				next_state.ssvid = {pl.bytes[39:32], pl.bytes[47:40]};
				next_state.ssid = {pl.bytes[23:16], pl.bytes[31:24]};
				next_state.mingnt = pl.bytes[15:8];
				next_state.maxlat = pl.bytes[7:0];
			end
		end

		// Read parity follows the driven AD by one clock
		next_state.pci.par = par36(state.pci.ad, pci_in.cbe_n);
		next_state.pci.par_oe = state.pci.ad_oe;

		// Target: an address phase is a falling FRAME# seen in T_IDLE or T_TURN; after a
		// data phase it served, T_DRAIN needs one idle cycle before the next address
		case (state.tst)
			ptcp_pkg::T_IDLE, ptcp_pkg::T_TURN:
			begin
				next_state.pci.tctl_oe = 1'b0;
				next_state.tst = ptcp_pkg::T_IDLE;
				if (!pci_in.frame_n && state.prev_frame_n && state.mst != ptcp_pkg::M_ADDR)
				begin
					next_state.addr = pci_in.ad;
					next_state.bcmd = pci_in.cbe_n;
					next_state.apar = par36(pci_in.ad, pci_in.cbe_n);
					next_state.tst = ptcp_pkg::T_DECODE;
				end
			end
			ptcp_pkg::T_DECODE:
			begin
				next_state.tst = ptcp_pkg::T_IDLE;
				if (pci_in.par != state.apar)
					next_state.dpe = 1'b1;
				else if (is_cfg || is_mem)
				begin
					next_state.pci.devsel_n = 1'b0;
					next_state.pci.trdy_n = 1'b1;
					next_state.pci.stop_n = 1'b1;
					next_state.pci.tctl_oe = 1'b1;
					if (busy)
					begin
						next_state.pci.stop_n = 1'b0;
						next_state.tst = ptcp_pkg::T_DRAIN;
					end
					else if (is_mem && !is_wr)
					begin
						next_state.rq = '{valid: 1'b1, write: 1'b0, offs: state.addr[8:0],
							wdata: 32'h00000000, be_n: 4'h0};
						next_state.tst = ptcp_pkg::T_RWAIT;
					end
					else
					begin
						next_state.pci.trdy_n = 1'b0;
						next_state.pci.stop_n = 1'b0;
						next_state.pci.ad = cfg_read(state, state.addr[7:0]);
						next_state.pci.ad_oe = !is_wr;
						next_state.tst = ptcp_pkg::T_DATA;
					end
				end
			end
			ptcp_pkg::T_RWAIT:
			begin
				// One data phase only, then disconnect
				next_state.pci.ad = reg_rdata;
				next_state.pci.ad_oe = 1'b1;
				next_state.pci.trdy_n = 1'b0;
				next_state.pci.stop_n = 1'b0;
				next_state.tst = ptcp_pkg::T_DATA;
			end
			ptcp_pkg::T_DATA:
			if (!pci_in.irdy_n)
			begin
				next_state.pci.trdy_n = 1'b1;
				next_state.pci.ad_oe = 1'b0;
				next_state.tst = ptcp_pkg::T_DRAIN;
				if (is_wr)
				begin
					next_state.dpar_pend = 1'b1;
					next_state.dpar_mst = 1'b0;
					next_state.dpar = par36(pci_in.ad, pci_in.cbe_n);
					if (!is_cfg)
						next_state.rq = '{valid: 1'b1, write: 1'b1, offs: state.addr[8:0],
							wdata: pci_in.ad, be_n: pci_in.cbe_n};
					else
						case (state.addr[7:0])
							`PTCP_OFS_CMDSTS:
							begin
								next_state.cmd = {w[`PTCP_CMD_FBB], w[`PTCP_CMD_PER],
									w[`PTCP_CMD_BME], w[`PTCP_CMD_MEM]};
								clr = pci_in.ad & m;
							end
							`PTCP_OFS_LAT: next_state.lat = w[15:8];
							`PTCP_OFS_BAR: next_state.bar = w[31:`PTCP_BAR_LSB];
							`PTCP_OFS_INTR: next_state.intline = w[7:0];
							default: next_state.lat = state.lat;
						endcase
				end
			end
			ptcp_pkg::T_DRAIN:
			if (pci_in.frame_n)
			begin
				// Drive high one clock before releasing
				next_state.pci.devsel_n = 1'b1;
				next_state.pci.stop_n = 1'b1;
				next_state.pci.trdy_n = 1'b1;
				next_state.tst = ptcp_pkg::T_TURN;
			end
			default: next_state.tst = ptcp_pkg::T_IDLE;
		endcase

		// Initiator: single data phase per grant, payload only from channels
		case (state.mst)
			ptcp_pkg::M_IDLE:
			if (state.cmd[1] && !busy && |req_vec)
			begin
				next_state.gidx = pick(req_vec, state.last);
				next_state.pci.req_n = 1'b0;
				next_state.mst = ptcp_pkg::M_REQ;
			end
			ptcp_pkg::M_REQ:
			if (!pci_in.gnt_n && pci_in.frame_n && pci_in.irdy_n)
			begin
				next_state.pci.req_n = 1'b1;
				next_state.pci.frame_n = 1'b0;
				next_state.pci.irdy_n = 1'b1;
				next_state.pci.mctl_oe = 1'b1;
				next_state.pci.ad = dma_req[state.gidx].addr;
				next_state.pci.ad_oe = 1'b1;
				next_state.pci.cbe_n = dma_req[state.gidx].write ? `PTCP_BC_MWR : `PTCP_BC_MRD;
				next_state.pci.cbe_oe = 1'b1;
				next_state.mst = ptcp_pkg::M_ADDR;
			end
			ptcp_pkg::M_ADDR:
			begin
				next_state.pci.frame_n = 1'b1;
				next_state.pci.irdy_n = 1'b0;
				next_state.pci.cbe_n = dma_req[state.gidx].be_n;
				next_state.pci.ad = dma_req[state.gidx].wdata;
				next_state.pci.ad_oe = dma_req[state.gidx].write;
				next_state.wcnt = 3'h0;
				next_state.mst = ptcp_pkg::M_DATA;
			end
			ptcp_pkg::M_DATA:
			begin
				next_state.wcnt = state.wcnt + 3'h1;
				if (!pci_in.trdy_n || !pci_in.stop_n || (pci_in.devsel_n
					&& state.wcnt == 3'(`PTCP_MABORT_CLKS - 1)))
				begin
					next_state.pci.irdy_n = 1'b1;
					next_state.pci.ad_oe = 1'b0;
					next_state.mst = ptcp_pkg::M_TURN;
				end
				if (!pci_in.trdy_n)
				begin
					next_state.done[state.gidx] = 1'b1;
					next_state.last = state.gidx;
					next_state.rdata = pci_in.ad;
					if (!dma_req[state.gidx].write)
					begin
						next_state.dpar_pend = 1'b1;
						next_state.dpar_mst = 1'b1;
						next_state.dpar = par36(pci_in.ad, pci_in.cbe_n);
					end
				end
				else if (!pci_in.stop_n && pci_in.devsel_n)
				begin
					next_state.rta = 1'b1;
					next_state.done[state.gidx] = 1'b1;
					next_state.err = 1'b1;
				end
				else if (pci_in.stop_n && pci_in.devsel_n
					&& state.wcnt == 3'(`PTCP_MABORT_CLKS - 1))
				begin
					next_state.rma = 1'b1;
					next_state.done[state.gidx] = 1'b1;
					next_state.err = 1'b1;
				end
			end
			ptcp_pkg::M_TURN:
			begin
				next_state.pci.mctl_oe = 1'b0;
				next_state.pci.cbe_oe = 1'b0;
				next_state.mst = ptcp_pkg::M_IDLE;
			end
			default: next_state.mst = ptcp_pkg::M_IDLE;
		endcase

		// Data parity check; PERR# two clocks after the data phase
		next_state.perr_cnt = (state.perr_cnt == 2'h0) ? 2'h0 : state.perr_cnt + 2'h1;
		next_state.pci.perr_n = 1'b1;
		next_state.pci.perr_oe = (state.perr_cnt == 2'h1);
		if (state.dpar_pend && pci_in.par != state.dpar)
		begin
			clr[`PTCP_STS_DPE] = 1'b0;
			next_state.dpe = 1'b1;
			if (state.cmd[2])
			begin
				next_state.pci.perr_n = 1'b0;
				next_state.pci.perr_oe = 1'b1;
				next_state.perr_cnt = 2'h1;
				if (state.dpar_mst)
				begin
					clr[`PTCP_STS_MDPE] = 1'b0;
					next_state.mdpe = 1'b1;
				end
			end
		end

		// Write-one-to-clear status; a same-cycle event wins unless RMA or RTA is already set
		if (clr[`PTCP_STS_DPE] && !next_state.dpe != !state.dpe)
			clr[`PTCP_STS_DPE] = 1'b0;
		next_state.dpe = next_state.dpe & !(clr[`PTCP_STS_DPE] && next_state.dpe == state.dpe);
		next_state.mdpe = next_state.mdpe & !(clr[`PTCP_STS_MDPE] && !next_state.mdpe == !state.mdpe);
		next_state.rma = next_state.rma & !(clr[`PTCP_STS_RMA] && next_state.rma == state.rma);
		next_state.rta = next_state.rta & !(clr[`PTCP_STS_RTA] && next_state.rta == state.rta);
	end

	always_ff @(posedge clk)
	begin
		if (srst)
		begin
			state <= '0;
			state.pci <= '{frame_n: 1'b1, irdy_n: 1'b1, trdy_n: 1'b1, devsel_n: 1'b1,
				stop_n: 1'b1, perr_n: 1'b1, req_n: 1'b1, cbe_n: 4'hf, default: '0};
			state.prev_frame_n <= 1'b1;
			state.ssvid <= `PTCP_SUBSYS_DEF;
			state.ssid <= `PTCP_SUBSYS_DEF;
			state.maxlat <= `PTCP_MAXLAT_DEF;
			state.mingnt <= `PTCP_MINGNT_DEF;
		end
		else
			state <= next_state;
	end

	assign pci_out = state.pci;
	assign reg_req = state.rq;
	assign dma_done = state.done;
	assign dma_err = state.err;
	assign dma_rdata = state.rdata;
	assign preload_busy = !state.loaded;
endmodule
`default_nettype wire

// >>> bench/ptcp_chk.sv
// Bus protocol assertions for the PCI target
`default_nettype none
module ptcp_chk (
	// Clock and reset
	input wire logic                    clk,
	input wire logic                    srst,
	// Watched ports
	input wire ptcp_pkg::ptcp_pci_in_t  pci_in,
	input wire ptcp_pkg::ptcp_pci_out_t pci_out,
	input wire logic                    preload_busy
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);
	a_retry_while_busy: assert property (
		preload_busy && $past(preload_busy) |-> pci_out.trdy_n) else $error("data in preload");
	a_addr_par_drop: assert property (
		$past(pci_in.frame_n) && !pci_in.frame_n ##1
		pci_in.par != ^$past({pci_in.ad, pci_in.cbe_n}) |=> pci_out.devsel_n)
		else $error("claimed bad address");
	a_perr_shape: assert property (
		$fell(pci_out.perr_n) |=> pci_out.perr_n ##1 !pci_out.perr_oe) else $error("perr shape");
	a_par_follows: assert property (
		pci_out.ad_oe |=> pci_out.par_oe && pci_out.par == ^$past({pci_out.ad, pci_in.cbe_n}))
		else $error("bad parity out");
	a_trdy_devsel: assert property (
		!pci_out.trdy_n |-> !pci_out.devsel_n && pci_out.tctl_oe) else $error("trdy alone");
	a_trdy_hold: assert property (
		!pci_out.trdy_n && pci_in.irdy_n |=> !pci_out.trdy_n) else $error("trdy dropped");
	a_stop_release: assert property (
		$rose(pci_out.stop_n) |-> $past(pci_in.frame_n)) else $error("stop dropped early");
	a_busy_stays: assert property (
		!preload_busy |=> !preload_busy) else $error("preload restarted");
endmodule
bind ptcp_pci_if ptcp_chk ptcp_chk_i (.clk(clk), .srst(srst), .pci_in(pci_in),
	.pci_out(pci_out), .preload_busy(preload_busy));
`default_nettype wire

// >>> bench/ptcp_ee_model.sv
// Serial memory stand-in that records the byte after START
`default_nettype none
module ptcp_ee_model (
	// Wire levels
	input wire logic   scl,
	input wire logic   sda,
	// Observed byte
	output logic [7:0] first_byte
);
	timeunit 1ns;
	timeprecision 100ps;
	int nbits = 8;
	// START restarts the count
	always @(negedge sda)
		if (scl)
			nbits = 0;
	// Never pulls the data line, so the address is refused
	always @(posedge scl)
		if (nbits < 8)
		begin
			first_byte = {first_byte[6:0], sda};
			nbits++;
		end
endmodule
`default_nettype wire

// >>> bench/tb_ptcp_pci_if.sv
// Testbench for the PCI target and its preload
`include "ptcp_cfg.svh"
`default_nettype none
module tb_ptcp_pci_if;
	timeunit 1ns;
	timeprecision 100ps;
	logic                    clk = 0;
	logic                    srst = 1;
	ptcp_pkg::ptcp_pci_in_t  drv;
	ptcp_pkg::ptcp_pci_in_t  pci_in;
	ptcp_pkg::ptcp_pci_out_t pci_out;
	ptcp_pkg::ptcp_dma_req_t dma_req [8];
	logic                    scl_oe;
	logic                    sda_oe;
	logic                    preload_busy;
	logic [7:0]              dma_done;
	logic                    dma_err;
	logic [7:0]              ee_byte;
	logic [31:0]             rd;
	int                      error_cnt = 0;
	int                      checks = 0;
	int                      perrs = 0;
	wire logic               scl = !scl_oe;
	wire logic               sda = !sda_oe;
	always #2 clk = !clk;
	// Wires: device drives under its enables, the bench otherwise; TRDY#, DEVSEL#, STOP# pull up
	always_comb
	begin
		pci_in = drv;
		pci_in.ad = pci_out.ad_oe ? pci_out.ad : drv.ad;
		pci_in.par = pci_out.par_oe ? pci_out.par : drv.par;
		pci_in.cbe_n = pci_out.cbe_oe ? pci_out.cbe_n : drv.cbe_n;
		pci_in.frame_n = pci_out.mctl_oe ? pci_out.frame_n : drv.frame_n;
		pci_in.irdy_n = pci_out.mctl_oe ? pci_out.irdy_n : drv.irdy_n;
		pci_in.trdy_n = !pci_out.tctl_oe | pci_out.trdy_n;
		pci_in.devsel_n = !pci_out.tctl_oe | pci_out.devsel_n;
		pci_in.stop_n = !pci_out.tctl_oe | pci_out.stop_n;
	end
	always @(posedge clk)
		if (!pci_out.perr_n && pci_out.perr_oe)
			perrs++;
	ptcp_pci_if #(.QTR_CLKS(2)) ptcp_pci_if_i (.clk(clk), .srst(srst), .pci_in(pci_in),
		.pci_out(pci_out), .scl_in(scl), .scl_out(), .scl_oe(scl_oe), .sda_in(sda),
		.sda_out(), .sda_oe(sda_oe), .reg_req(), .reg_rdata(32'h0), .dma_req(dma_req),
		.dma_done(dma_done), .dma_err(dma_err), .dma_rdata(), .preload_busy(preload_busy));
	ptcp_ee_model ptcp_ee_model_i (.scl(scl), .sda(sda), .first_byte(ee_byte));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// One config access, single data phase; bad[0] spoils address, bad[1] data parity
	task automatic cyc(input logic wr, input logic [7:0] offs, input logic [31:0] wd,
		input logic [3:0] be, input logic [1:0] bad);
		drv.frame_n = 0;
		drv.ad = {24'h0, offs};
		drv.cbe_n = wr ? `PTCP_BC_CWR : `PTCP_BC_CRD;
		@(posedge clk) #1;
		drv.par = ^{drv.ad, drv.cbe_n} ^ bad[0];
		drv.frame_n = 1;
		drv.irdy_n = 0;
		drv.cbe_n = be;
		drv.ad = wd;
		for (int n = 0; n < 8 && pci_in.stop_n && pci_in.trdy_n; n++)
			@(posedge clk) #1;
		rd = wr ? {29'h0, pci_in.devsel_n, pci_in.stop_n, pci_in.trdy_n} : pci_in.ad;
		@(posedge clk) #1;
		drv.irdy_n = 1;
		drv.par = ^{wd, be} ^ bad[1];
		repeat (3) @(posedge clk) #1;
	endtask
	task automatic t_preload();
		chk(preload_busy, 1);
		cyc(1, `PTCP_OFS_INTR, 0, 0, 0);
		chk(rd, 1);
		for (int n = 0; n < 4000 && preload_busy; n++)
			@(posedge clk) #1;
		chk(preload_busy, 0);
		if (preload_busy)
			final_report();
		chk(ee_byte, 8'ha0);
		$display("t_preload done");
	endtask
	task automatic t_space();
		logic [7:0]  offs [6] = '{8'h3c, 8'h2c, 8'h0c, 8'h0c, 8'h28, 8'h10};
		logic [3:0]  be [6] = '{4'h0, 4'h0, 4'h0, 4'hf, 4'h0, 4'h0};
		logic [31:0] exp [6] = '{32'h260f01ff, 32'h0, 32'h0000ff00, 32'h0000ff00, 32'h0,
			32'hfffffe00};
		for (int i = 0; i < 6; i++)
		begin
			cyc(1, offs[i], {32{i != 3}}, be[i], 0);
			cyc(0, offs[i], 0, 4'h0, 0);
			chk(rd, exp[i]);
		end
		$display("t_space done");
	endtask
	task automatic t_parity();
		cyc(0, `PTCP_OFS_ID, 0, 4'h0, 1);
		chk(rd, 32'h0);
		cyc(0, `PTCP_OFS_CMDSTS, 0, 4'h0, 0);
		chk(rd, 32'h82800000);
		cyc(1, `PTCP_OFS_CMDSTS, 32'h80000040, 4'h0, 0);
		cyc(1, `PTCP_OFS_INTR, 0, 4'h0, 2);
		chk(perrs, 1);
		cyc(0, `PTCP_OFS_CMDSTS, 0, 4'h0, 0);
		chk(rd, 32'h82800040);
		$display("t_parity done");
	endtask
	// Own read with nobody claiming it: master abort, error pulse, Status bit29
	task automatic t_master();
		cyc(1, `PTCP_OFS_CMDSTS, 32'h00000004, 4'h0, 0);
		dma_req[0] = '{valid: 1'b1, write: 1'b0, addr: 32'h00001000, wdata: 32'h0, be_n: 4'h0};
		drv.gnt_n = 0;
		for (int n = 0; n < 40 && !dma_done[0]; n++)
			@(posedge clk) #1;
		chk(dma_done[0], 1);
		chk(dma_err, 1);
		dma_req[0].valid = 0;
		drv.gnt_n = 1;
		repeat (3) @(posedge clk) #1;
		cyc(0, `PTCP_OFS_CMDSTS, 0, 4'h0, 0);
		chk(rd, 32'ha2800004);
		$display("t_master done");
	endtask
	initial
	begin
		drv = '1;
		drv.ad = 32'h0;
		foreach (dma_req[i])
			dma_req[i] = '0;
		repeat (12) @(posedge clk) #1;
		srst = 0;
		t_preload();
		t_space();
		t_parity();
		t_master();
		final_report();
	end
endmodule
`default_nettype wire
